/* pcx_assign.sv */
/*
 * Pin assignment decoder: places fixed signals on their pins, then gives
 * each enabled flexible signal the lowest free, unskipped pin.
 * Assumes purely combinational use; the caller registers the result.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pcx_params.svh"

module pcx_assign
  import pcx_pkg::*;
(
  // map carrier
  pcx_map_if.dec m
);

  pcx_pins_t blocked;
  logic      found;

  function automatic pcx_pin_t fixed_pin(input int s);
    case (s)
      `PCX_S_TX:     fixed_pin = `PCX_PIN_TX;
      `PCX_S_RX:     fixed_pin = `PCX_PIN_RX;
      `PCX_S_CAN_TX: fixed_pin = `PCX_PIN_CAN_TX;
      `PCX_S_CAN_RX: fixed_pin = `PCX_PIN_CAN_RX;
      default:       fixed_pin = `PCX_PIN_NONE;
    endcase
  endfunction

  // ****************************************
  // decoder
  // ****************************************
  always_comb begin
    blocked                               = '0;
    blocked[`PCX_NPIN-1:`PCX_P3_BASE]     = m.skip3;
    m.sig_placed                          = '0;
    m.pin_used                            = '0;
    found                                 = 1'b0;
    for (int p = 0; p < `PCX_NPIN; p++) begin
      m.pin_sel[p] = '0;
    end
    for (int s = 0; s < `PCX_NSIG; s++) begin
      m.sig_pin[s] = '0;
    end
    // fixed pins first, so flexible signals go round them
    for (int s = `PCX_NFLEX; s < `PCX_NSIG; s++) begin
      if (m.sig_en[s]) begin
        blocked[fixed_pin(s)]    = 1'b1;
        m.pin_used[fixed_pin(s)] = 1'b1;
        m.pin_sel[fixed_pin(s)]  = 4'(s);
        m.sig_pin[s]             = fixed_pin(s);
        m.sig_placed[s]          = 1'b1;
      end
    end
    // flexible signals in priority order, lowest free pin wins
    for (int s = 0; s < `PCX_NFLEX; s++) begin
      found = 1'b0;
      for (int p = 0; p < `PCX_NPIN; p++) begin
        if (m.sig_en[s] && !found && !blocked[p]) begin
          found           = 1'b1;
          blocked[p]      = 1'b1;
          m.pin_used[p]   = 1'b1;
          m.pin_sel[p]    = 4'(s);
          m.sig_pin[s]    = 5'(p);
          m.sig_placed[s] = 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* pcx_crossbar_top.sv */
/*
 * Port I/O crossbar: two configuration registers on the special-function
 * register bus, a pin assignment decoder, registered pin drive and
 * synchronised return of pin levels to the peripherals.
 * Assumes the register strobes and peripheral signals run on clk_in and
 * the pin inputs are asynchronous; pin pads resolve levels from the enables.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pcx_params.svh"

module pcx_crossbar_top
  import pcx_pkg::*;
(
  // clock and reset
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  // special-function register bus
  input  wire logic      sfr_wr_in,
  input  wire logic      sfr_rd_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_page_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  // peripheral side
  input  wire logic [`PCX_NSIG-1:0] periph_out_in,
  input  wire logic [`PCX_NSIG-1:0] periph_oe_in,
  input  wire logic                 spi_four_wire_in,
  output logic      [`PCX_NSIG-1:0] periph_in_out,
  // general-purpose I/O side
  input  wire logic [`PCX_NPIN-1:0] gpio_out_in,
  input  wire logic [`PCX_NPIN-1:0] gpio_oe_in,
  output logic      [`PCX_NPIN-1:0] gpio_in_out,
  // pins
  input  wire logic [`PCX_NPIN-1:0] pin_in_in,
  output logic      [`PCX_NPIN-1:0] pin_out_out,
  output logic      [`PCX_NPIN-1:0] pin_oe_out
);

  pcx_byte_t en0_r;
  pcx_byte_t skip3_r;
  pcx_byte_t rdata_r;
  pcx_pins_t pin_sync1_r;
  pcx_pins_t pin_sync2_r;
  pcx_pins_t pin_out_r;
  pcx_pins_t pin_out_nxt;
  pcx_pins_t pin_oe_r;
  pcx_pins_t pin_oe_nxt;
  pcx_sigs_t periph_in_r;
  pcx_sigs_t periph_in_nxt;
  logic      page_hit;

  pcx_map_if m ();

  pcx_assign u_assign (
    .m (m.dec)
  );

  // ****************************************
  // register bus
  // ****************************************
  assign page_hit = (sfr_page_in == `PCX_SFR_PAGE);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en0_r <= `PCX_RST_EN0;
    end else if (sfr_wr_in && page_hit && sfr_addr_in == `PCX_ADDR_EN0) begin
      en0_r <= sfr_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      skip3_r <= `PCX_RST_SKIP3;
    end else if (sfr_wr_in && page_hit && sfr_addr_in == `PCX_ADDR_SKIP3) begin
      skip3_r <= sfr_wdata_in;
    end
  end

  // read data registered on the read strobe, held until the next read
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= `PCX_RDATA_NONE;
    end else if (sfr_rd_in) begin
      if (page_hit && sfr_addr_in == `PCX_ADDR_EN0) begin
        rdata_r <= en0_r;
      end else if (page_hit && sfr_addr_in == `PCX_ADDR_SKIP3) begin
        rdata_r <= skip3_r;
      end else begin
        rdata_r <= `PCX_RDATA_NONE;
      end
    end
  end

  // ****************************************
  // signal enables
  // ****************************************
  always_comb begin
    m.sig_en                        = '0;
    m.sig_en[`PCX_S_SDA]            = en0_r[`PCX_B_TWOWIRE];
    m.sig_en[`PCX_S_SCL]            = en0_r[`PCX_B_TWOWIRE];
    m.sig_en[`PCX_S_SCK]            = en0_r[`PCX_B_SPI];
    m.sig_en[`PCX_S_MISO]           = en0_r[`PCX_B_SPI];
    m.sig_en[`PCX_S_MOSI]           = en0_r[`PCX_B_SPI];
    m.sig_en[`PCX_S_NSS]            = en0_r[`PCX_B_SPI] && spi_four_wire_in;
    m.sig_en[`PCX_S_CMP0]           = en0_r[`PCX_B_CMP0];
    m.sig_en[`PCX_S_CMP0_ASYNC]     = en0_r[`PCX_B_CMP0_ASYNC];
    m.sig_en[`PCX_S_CMP1]           = en0_r[`PCX_B_CMP1];
    m.sig_en[`PCX_S_CMP1_ASYNC]     = en0_r[`PCX_B_CMP1_ASYNC];
    m.sig_en[`PCX_S_TX]             = en0_r[`PCX_B_UART];
    m.sig_en[`PCX_S_RX]             = en0_r[`PCX_B_UART];
    m.sig_en[`PCX_S_CAN_TX]         = en0_r[`PCX_B_FIELDBUS];
    m.sig_en[`PCX_S_CAN_RX]         = en0_r[`PCX_B_FIELDBUS];
  end

  // skip only bites once the flexible signals spill past port 2
  assign m.skip3 = skip3_r;

  // ****************************************
  // pin drive and return path
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_sync1_r <= '0;
      pin_sync2_r <= '0;
    end else begin
      pin_sync1_r <= pin_in_in;
      pin_sync2_r <= pin_sync1_r;
    end
  end

  for (genvar gp = 0; gp < `PCX_NPIN; gp++) begin : g_pin
    // unassigned pins stay general-purpose
    assign pin_out_nxt[gp] = m.pin_used[gp] ? periph_out_in[m.pin_sel[gp]] : gpio_out_in[gp];
    assign pin_oe_nxt[gp]  = m.pin_used[gp] ? periph_oe_in[m.pin_sel[gp]] : gpio_oe_in[gp];
  end

  for (genvar gs = 0; gs < `PCX_NSIG; gs++) begin : g_sig
    // an unrouted input idles high
    assign periph_in_nxt[gs] = m.sig_placed[gs] ? pin_sync2_r[m.sig_pin[gs]] : 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out_r   <= '0;
      pin_oe_r    <= '0;
      periph_in_r <= '1;
    end else begin
      pin_out_r   <= pin_out_nxt;
      pin_oe_r    <= pin_oe_nxt;
      periph_in_r <= periph_in_nxt;
    end
  end

  assign sfr_rdata_out = rdata_r;
  assign pin_out_out   = pin_out_r;
  assign pin_oe_out    = pin_oe_r;
  assign periph_in_out = periph_in_r;
  assign gpio_in_out   = pin_sync2_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // uart enable held long enough for a level to cross the return path
  sequence uart_held_s;
    en0_r[`PCX_B_UART] [*4];
  endsequence

  sequence twowire_alone_s;
    (en0_r == 8'h08);
  endsequence

  cmp_route_a: assert property (m.sig_placed[9:6] == en0_r[7:4])
    else $error("comparator routing differs from its enables");
  twowire_off_a: assert property (!en0_r[`PCX_B_TWOWIRE] |-> !m.sig_placed[1] && !m.sig_placed[0])
    else $error("two-wire line routed while disabled");
  twowire_on_a: assert property (en0_r[`PCX_B_TWOWIRE] |-> m.sig_placed[1] && m.sig_placed[0])
    else $error("two-wire line missing while enabled");
  twowire_first_a: assert property (twowire_alone_s |=> pin_oe_r[0] == $past(periph_oe_in[`PCX_S_SDA]))
    else $error("two-wire data not on lowest pin");
  spi_count_a: assert property (en0_r[`PCX_B_SPI] |->
    $countones(m.sig_placed[5:2]) == (spi_four_wire_in ? 4 : 3))
    else $error("wrong number of serial peripheral pins");
  spi_off_a: assert property (!en0_r[`PCX_B_SPI] |-> m.sig_placed[5:2] == 4'h0)
    else $error("serial peripheral line routed while disabled");
  fieldbus_pin_a: assert property (en0_r[`PCX_B_FIELDBUS] |=>
    pin_out_r[`PCX_PIN_CAN_TX] == $past(periph_out_in[`PCX_S_CAN_TX]))
    else $error("fieldbus transmit not on its pin");
  fieldbus_off_a: assert property (!en0_r[`PCX_B_FIELDBUS] |-> m.sig_placed[13:12] == 2'h0)
    else $error("fieldbus line routed while disabled");
  uart_pin_a: assert property (en0_r[`PCX_B_UART] |=>
    pin_oe_r[`PCX_PIN_TX] == $past(periph_oe_in[`PCX_S_TX]))
    else $error("serial transmit not on its pin");
  uart_rx_pin_a: assert property (en0_r[`PCX_B_UART] |-> m.sig_pin[`PCX_S_RX] == `PCX_PIN_RX)
    else $error("serial receive not on its pin");
  uart_off_a: assert property (!en0_r[`PCX_B_UART] |-> m.sig_placed[11:10] == 2'h0)
    else $error("serial line routed while disabled");
  uart_return_a: assert property (uart_held_s |->
    periph_in_r[`PCX_S_RX] == $past(pin_in_in[`PCX_PIN_RX], 3))
    else $error("serial receive level not returned");
  skip_pin_a: assert property ((m.pin_used[31:24] & skip3_r) == 8'h00)
    else $error("skipped port 3 pin was assigned");
  gpio_free_a: assert property (!m.pin_used[31] |=> pin_out_r[31] == $past(gpio_out_in[31]))
    else $error("free pin does not follow its plain output");
  read_back_a: assert property (sfr_rd_in && page_hit && sfr_addr_in == `PCX_ADDR_EN0 |=>
    sfr_rdata_out == $past(en0_r))
    else $error("enable register read back wrong");
  // read data stands between read strobes
  rdata_hold_a: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
    else $error("read data changed without a read");

endmodule

`default_nettype wire

/* pcx_map_if.sv */
/*
 * Carrier between the crossbar top and its pin assignment decoder.
 * Assumes pcx_pkg is compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pcx_params.svh"

interface pcx_map_if;
  import pcx_pkg::*;
  pcx_sigs_t sig_en;
  pcx_byte_t skip3;
  pcx_sigs_t sig_placed;
  pcx_pins_t pin_used;
  pcx_pin_t  sig_pin [`PCX_NSIG];
  pcx_sig_t  pin_sel [`PCX_NPIN];

  modport ctrl (output sig_en, output skip3, input sig_placed, input pin_used, input sig_pin, input pin_sel);
  modport dec  (input sig_en, input skip3, output sig_placed, output pin_used, output sig_pin, output pin_sel);
endinterface

`default_nettype wire

/* pcx_pad_model.sv */
/*
 * Pad model at the far side of the crossbar: resolves each pin level.
 * Assumes the pin drive outputs of pcx_crossbar_top; no pull on any pin.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pcx_params.svh"

module pcx_pad_model
  import pcx_pkg::*;
(
  // drive from the crossbar
  input  wire logic [`PCX_NPIN-1:0] pin_out_in,
  input  wire logic [`PCX_NPIN-1:0] pin_oe_in,
  // resolved levels
  output logic      [`PCX_NPIN-1:0] pin_lvl_out
);
  pcx_pins_t last_drv;

  initial last_drv = '0;
  // floating pin shows the inverse of its last driven level
  always @* begin
    for (int i = 0; i < `PCX_NPIN; i++) begin
      if (pin_oe_in[i])
        last_drv[i] = pin_out_in[i];
    end
  end
  assign pin_lvl_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ~last_drv);
endmodule

`default_nettype wire

/* pcx_params.svh */
/*
 * Constants of the port I/O crossbar: register addresses, field positions,
 * reset values, signal indices and fixed pin numbers.
 * Assumes it is included by its bare name, before any code that uses it.
 */
`ifndef PCX_PARAMS_SVH
`define PCX_PARAMS_SVH

// ****************************************
// register access
// ****************************************
`define PCX_ADDR_SKIP3     8'hd7
`define PCX_ADDR_EN0       8'he1
`define PCX_SFR_PAGE       8'h0f
`define PCX_RST_SKIP3      8'h00
`define PCX_RST_EN0        8'h00
`define PCX_RDATA_NONE     8'h00

// ****************************************
// crossbar_enable_0 fields
// ****************************************
`define PCX_B_CMP1_ASYNC   7
`define PCX_B_CMP1         6
`define PCX_B_CMP0_ASYNC   5
`define PCX_B_CMP0         4
`define PCX_B_TWOWIRE      3
`define PCX_B_SPI          2
`define PCX_B_FIELDBUS     1
`define PCX_B_UART         0

// ****************************************
// sizes, signal indices in priority order
// ****************************************
`define PCX_NPIN           32
`define PCX_NSIG           14
`define PCX_NFLEX          10
`define PCX_P3_BASE        24
`define PCX_S_SDA          0
`define PCX_S_SCL          1
`define PCX_S_SCK          2
`define PCX_S_MISO         3
`define PCX_S_MOSI         4
`define PCX_S_NSS          5
`define PCX_S_CMP0         6
`define PCX_S_CMP0_ASYNC   7
`define PCX_S_CMP1         8
`define PCX_S_CMP1_ASYNC   9
`define PCX_S_TX           10
`define PCX_S_RX           11
`define PCX_S_CAN_TX       12
`define PCX_S_CAN_RX       13

// ****************************************
// fixed pins (port*8 + bit)
// ****************************************
`define PCX_PIN_TX         5'h04
`define PCX_PIN_RX         5'h05
`define PCX_PIN_CAN_TX     5'h06
`define PCX_PIN_CAN_RX     5'h07
`define PCX_PIN_NONE       5'h00

`endif

/* pcx_pkg.sv */
/*
 * Types of the port I/O crossbar.
 * Assumes pcx_params.svh sits in the same folder.
 */
`include "pcx_params.svh"

package pcx_pkg;
  typedef logic [`PCX_NPIN-1:0] pcx_pins_t;
  typedef logic [`PCX_NSIG-1:0] pcx_sigs_t;
  typedef logic [3:0]           pcx_sig_t;
  typedef logic [4:0]           pcx_pin_t;
  typedef logic [7:0]           pcx_byte_t;
endpackage

/* pcx_tb.sv */
/*
 * Self-checking bench of the port I/O crossbar.
 * Assumes pcx_pkg, pcx_params.svh and the design files compile first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pcx_params.svh"

module tb;
  import pcx_pkg::*;
  logic      clk_in = 1'b0;
  logic      rst_n_in = 1'b0;
  logic      sfr_wr_in = 1'b0;
  logic      sfr_rd_in = 1'b0;
  logic      spi_four_wire_in = 1'b0;
  pcx_byte_t sfr_addr_in = 8'h00;
  pcx_byte_t sfr_page_in = 8'h00;
  pcx_byte_t sfr_wdata_in = 8'h00;
  pcx_byte_t sfr_rdata_out;
  pcx_byte_t rd_v;
  pcx_sigs_t periph_out_in = 14'h2b5a;
  pcx_sigs_t periph_oe_in = 14'h17f7;
  pcx_sigs_t periph_in_out;
  pcx_sigs_t exp_on;
  pcx_sigs_t exp_in;
  pcx_pins_t gpio_out_in = 32'h5a5a5a5a;
  pcx_pins_t gpio_oe_in = 32'h00ff00f0;
  pcx_pins_t gpio_in_out;
  pcx_pins_t pin_in_in;
  pcx_pins_t pin_out_out;
  pcx_pins_t pin_oe_out;
  pcx_pins_t exp_oe;
  pcx_pins_t exp_out;
  int        exp_pin [`PCX_NSIG];
  int        miscompares = 0;
  int        checked = 0;
  int        cycles = 0;
  logic [16:0] tbl [14] = '{17'h00800, 17'h00400, 17'h10400, 17'h00100, 17'h00200, 17'h01000, 17'h02000,
                            17'h04000, 17'h08000, 17'h1ffff, 17'h0ff00, 17'h0f5aa, 17'h10d00, 17'h00000};

  always #50 clk_in = ~clk_in;

  pcx_crossbar_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_addr_in(sfr_addr_in), .sfr_page_in(sfr_page_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out), .periph_out_in(periph_out_in), .periph_oe_in(periph_oe_in),
    .spi_four_wire_in(spi_four_wire_in), .periph_in_out(periph_in_out), .gpio_out_in(gpio_out_in),
    .gpio_oe_in(gpio_oe_in), .gpio_in_out(gpio_in_out), .pin_in_in(pin_in_in),
    .pin_out_out(pin_out_out), .pin_oe_out(pin_oe_out));
  pcx_pad_model pad_u (.pin_out_in(pin_out_out), .pin_oe_in(pin_oe_out), .pin_lvl_out(pin_in_in));

  // ****************************************
  // reporting
  // ****************************************
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp_v(input pcx_pins_t got, input pcx_pins_t exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_b(input pcx_byte_t got, input pcx_byte_t exp, input string what);
    cmp_v({24'h000000, got}, {24'h000000, exp}, what);
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  task automatic reg_wr(input pcx_byte_t pg, input pcx_byte_t ad, input pcx_byte_t d);
    @(posedge clk_in);
    sfr_wr_in <= 1'b1;
    sfr_page_in <= pg;
    sfr_addr_in <= ad;
    sfr_wdata_in <= d;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask

  task automatic reg_rd(input pcx_byte_t pg, input pcx_byte_t ad, output pcx_byte_t d);
    @(posedge clk_in);
    sfr_rd_in <= 1'b1;
    sfr_page_in <= pg;
    sfr_addr_in <= ad;
    @(posedge clk_in);
    sfr_rd_in <= 1'b0;
    #1;
    d = sfr_rdata_out;
  endtask

  // ****************************************
  // expected map and one case
  // ****************************************
  task automatic run_case(input pcx_byte_t x, input pcx_byte_t sk, input logic fw);
    pcx_pins_t used;
    int        p;
    used = '0;
    p = 0;
    @(posedge clk_in);
    spi_four_wire_in <= fw;
    gpio_out_in <= ~gpio_out_in;
    periph_out_in <= ~periph_out_in;
    reg_wr(`PCX_SFR_PAGE, `PCX_ADDR_SKIP3, sk);
    reg_wr(`PCX_SFR_PAGE, `PCX_ADDR_EN0, x);
    exp_on = {x[1], x[1], x[0], x[0], x[7], x[6], x[5], x[4], x[2] & fw, x[2], x[2], x[2], x[3], x[3]};
    for (int s = 10; s < `PCX_NSIG; s++) begin
      exp_pin[s] = s - 6;
      used[s-6] = exp_on[s];
    end
    for (int s = 0; s < 10; s++) begin
      while (p < `PCX_NPIN && (used[p] || (p >= `PCX_P3_BASE && sk[p%8])))
        p++;
      exp_pin[s] = p;
      if (exp_on[s] && p < `PCX_NPIN)
        used[p] = 1'b1;
    end
    repeat (5) @(posedge clk_in);
    #1;
    exp_oe = gpio_oe_in;
    exp_out = gpio_out_in;
    for (int s = 0; s < `PCX_NSIG; s++) begin
      exp_in[s] = exp_on[s] ? pin_in_in[exp_pin[s]] : 1'b1;
      if (exp_on[s]) begin
        exp_oe[exp_pin[s]] = periph_oe_in[s];
        exp_out[exp_pin[s]] = periph_out_in[s];
      end
    end
    cmp_v(pin_oe_out, exp_oe, "pin enables");
    cmp_v(pin_out_out, exp_out, "pin values");
    cmp_v({18'h0, periph_in_out}, {18'h0, exp_in}, "returned levels");
    cmp_v(gpio_in_out, pin_in_in, "plain levels");
    reg_rd(`PCX_SFR_PAGE, `PCX_ADDR_EN0, rd_v);
    cmp_b(rd_v, x, "enable readback");
    reg_rd(`PCX_SFR_PAGE, `PCX_ADDR_SKIP3, rd_v);
    cmp_b(rd_v, sk, "skip readback");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_in);
    #1;
    cmp_v(pin_oe_out, 32'h00000000, "reset enables");
    cmp_v({18'h0, periph_in_out}, {18'h0, 14'h3fff}, "reset returns");
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    reg_rd(`PCX_SFR_PAGE, `PCX_ADDR_EN0, rd_v);
    cmp_b(rd_v, `PCX_RST_EN0, "enable reset");
    reg_rd(`PCX_SFR_PAGE, `PCX_ADDR_SKIP3, rd_v);
    cmp_b(rd_v, `PCX_RST_SKIP3, "skip reset");
    // wrong page is ignored, unmapped address reads zero
    reg_wr(8'h00, `PCX_ADDR_EN0, 8'hff);
    reg_rd(`PCX_SFR_PAGE, `PCX_ADDR_EN0, rd_v);
    cmp_b(rd_v, `PCX_RST_EN0, "wrong page write");
    reg_rd(`PCX_SFR_PAGE, 8'he2, rd_v);
    cmp_b(rd_v, `PCX_RDATA_NONE, "unmapped read");
    for (int i = 0; i < 14; i++)
      run_case(tbl[i][15:8], tbl[i][7:0], tbl[i][16]);
    // reset in mid-run clears both registers and every drive
    reg_wr(`PCX_SFR_PAGE, `PCX_ADDR_EN0, 8'hff);
    reg_wr(`PCX_SFR_PAGE, `PCX_ADDR_SKIP3, 8'h5a);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    cmp_v(pin_oe_out, 32'h00000000, "mid-run reset enables");
    cmp_v({18'h0, periph_in_out}, {18'h0, 14'h3fff}, "mid-run reset returns");
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    reg_rd(`PCX_SFR_PAGE, `PCX_ADDR_EN0, rd_v);
    cmp_b(rd_v, `PCX_RST_EN0, "mid-run enable reset");
    reg_rd(`PCX_SFR_PAGE, `PCX_ADDR_SKIP3, rd_v);
    cmp_b(rd_v, `PCX_RST_SKIP3, "mid-run skip reset");
    end_sim();
  end
endmodule

`default_nettype wire
